// ==== hdl/pwmtb_pkg.sv ====
// Constants, types and decoders for the motor PWM time base block.
// Assumes one clock domain and APB byte addresses on 32-bit words.
package pwmtb_pkg;
  localparam int TB_W   = 15;
  localparam int DUTY_W = 16;
  localparam int DT_W   = 6;
  localparam int N_DUTY = 4;
  localparam int N_PAIR = 3;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_DUTY0  = 8'h0C;
  localparam logic [7:0] ADDR_OUTCFG = 8'h1C;
  localparam logic [7:0] ADDR_OUTCTL = 8'h20;
  localparam logic [7:0] ADDR_DTCTL  = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  // Field positions
  localparam int CTRL_RUN_BIT = 15;
  localparam int CTRL_POS_LSB = 4;
  localparam int CTRL_PRE_LSB = 2;
  localparam int CNT_DIR_BIT  = 15;
  localparam int DTC_PSA_LSB  = 6;
  localparam int DTC_PSB_LSB  = 8;
  // Reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [14:0] PER_RST   = 15'h0000;
  localparam logic [15:0] DUTY_RST  = 16'h0000;
  localparam logic [2:0]  INDEP_RST = 3'h0;
  localparam logic [9:0]  DTC_RST   = 10'h000;
  typedef enum logic [1:0] {MODE_FREE, MODE_ONESHOT, MODE_UPDN, MODE_DBL} pwmtb_mode_e;
  // Terminal count of the time base prescaler
  function automatic logic [5:0] pwmtb_pre_term(input logic [1:0] sel);
    case (sel)
      2'h0:    pwmtb_pre_term = 6'h00;
      2'h1:    pwmtb_pre_term = 6'h03;
      2'h2:    pwmtb_pre_term = 6'h0F;
      default: pwmtb_pre_term = 6'h3F;
    endcase
  endfunction
  // Terminal count of the dead-time prescaler
  function automatic logic [2:0] pwmtb_dt_term(input logic [1:0] sel);
    case (sel)
      2'h0:    pwmtb_dt_term = 3'h0;
      2'h1:    pwmtb_dt_term = 3'h1;
      2'h2:    pwmtb_dt_term = 3'h3;
      default: pwmtb_dt_term = 3'h7;
    endcase
  endfunction
endpackage

// ==== hdl/pwmtb_dt_if.sv ====
// Dead-time configuration carried from the register file to each pair.
// Assumes all pairs share one dead-time setting.
`timescale 1ns/10ps
interface pwmtb_dt_if;
  logic [5:0] dt_val;
  logic [1:0] ps_a;
  logic [1:0] ps_b;
  logic       dt_wr;
  modport ctl  (output dt_val, ps_a, ps_b, dt_wr);
  modport unit (input dt_val, ps_a, ps_b, dt_wr);
endinterface

// ==== hdl/pwmtb_duty.sv ====
// One duty comparison unit: buffer, active register and compare level.
// Assumes loads come from the time base at cycle boundaries, or every cycle while it is stopped, except with lockout in edge modes.
`timescale 1ns/10ps
module pwmtb_duty
  import pwmtb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  input  wire logic        load,
  input  wire logic [15:0] cnt_ext,
  input  wire logic [14:0] period,
  input  wire logic        center,
  output logic      [15:0] buf_val,
  output logic             cmp
);
  logic [15:0] buf_ff;
  logic [15:0] act_ff;
  // Software side buffer
  always_ff @(posedge clk)
  begin
    if (srst) buf_ff <= DUTY_RST;
    else if (wr) buf_ff <= wdata;
  end
  // Active compare value changes only at boundaries or while the time base is stopped, so no glitches
  always_ff @(posedge clk)
  begin
    if (srst) act_ff <= DUTY_RST;
    else if (load) act_ff <= buf_ff;
  end
  assign buf_val = buf_ff;
  // Level compare on half-count scale; full-on case in center mode
  assign cmp = (cnt_ext < act_ff) ||
               (center && act_ff != DUTY_RST && act_ff[15:1] == period);
  AST_DUTY_ZERO: assert property (@(posedge clk) disable iff (srst)
    act_ff == DUTY_RST |-> !cmp) else $error("zero duty drove output active");
  AST_DUTY_LOAD: assert property (@(posedge clk) disable iff (srst)
    load |=> act_ff == $past(buf_ff)) else $error("duty buffer not loaded");
endmodule

// ==== hdl/pwmtb_deadtime.sv ====
// Dead-time generator for one output pair, with registered outputs.
// Assumes the compare level is free of glitches from cycle to cycle.
`timescale 1ns/10ps
module pwmtb_deadtime
  import pwmtb_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  cmp,
  input  wire logic  indep,
  pwmtb_dt_if.unit   dtc,
  output logic       hi_out,
  output logic       lo_out
);
  logic       cmp_q_ff;
  logic       rise_ff;
  logic [5:0] cnt_ff;
  logic [2:0] pre_ff;
  logic [2:0] term;
  logic       edge_ev;
  logic       hold;
  logic       hi_ff;
  logic       lo_ff;
  assign edge_ev = cmp ^ cmp_q_ff;
  // Rising edges delay the high side with A, falling delay the low side with B
  assign term = rise_ff ? pwmtb_dt_term(dtc.ps_a) : pwmtb_dt_term(dtc.ps_b);
  assign hold = edge_ev ? (dtc.dt_val != 6'h00)
                        : (cnt_ff > 6'h01 || (cnt_ff == 6'h01 && pre_ff != term));
  // Edge detector and edge direction
  always_ff @(posedge clk)
  begin
    if (srst) cmp_q_ff <= 1'b0;
    else cmp_q_ff <= cmp;
    if (srst) rise_ff <= 1'b0;
    else if (edge_ev) rise_ff <= cmp;
  end
  // Prescaler restarts with each load so every dead time is full length
  always_ff @(posedge clk)
  begin
    if (srst || edge_ev || dtc.dt_wr) pre_ff <= 3'h0;
    else if (cnt_ff != 6'h00) pre_ff <= (pre_ff == term) ? 3'h0 : pre_ff + 3'h1;
  end
  // Down counter
  always_ff @(posedge clk)
  begin
    if (srst) cnt_ff <= 6'h00;
    else if (edge_ev && !indep) cnt_ff <= dtc.dt_val;
    else if (cnt_ff != 6'h00 && pre_ff == term) cnt_ff <= cnt_ff - 6'h01;
  end
  // Outputs: both inactive while counting, independent pairs skip it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hi_ff <= 1'b0;
      lo_ff <= 1'b0;
    end
    else if (indep)
    begin
      hi_ff <= cmp;
      lo_ff <= cmp;
    end
    else
    begin
      hi_ff <= !hold && cmp;
      lo_ff <= !hold && !cmp;
    end
  end
  assign hi_out = hi_ff;
  assign lo_out = lo_ff;
  AST_DT_HOLD: assert property (@(posedge clk) disable iff (srst)
    edge_ev && !indep && dtc.dt_val != 6'h00 |=> !hi_ff && !lo_ff)
    else $error("dead time not inserted after compare edge");
  AST_NO_SHOOT: assert property (@(posedge clk) disable iff (srst)
    !$past(indep) |-> !(hi_ff && lo_ff)) else $error("both pair outputs active");
endmodule

// ==== hdl/pwmtb_top.sv ====
// Motor PWM time base, duty comparison and dead-time top level.
// Assumes an APB master on SYS_CLK and gate drivers on the pair outputs.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module pwmtb_top
  import pwmtb_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             TB_EVENT,
  output logic             PAIR_ONE_HIGH_OUT,
  output logic             PAIR_ONE_LOW_OUT,
  output logic             PAIR_TWO_HIGH_OUT,
  output logic             PAIR_TWO_LOW_OUT,
  output logic             PAIR_THREE_HIGH_OUT,
  output logic             PAIR_THREE_LOW_OUT
);
  logic              run_ff;
  logic [1:0]        mode_ff;
  logic [1:0]        pre_sel_ff;
  logic [3:0]        post_sel_ff;
  logic [14:0]       count_ff;
  logic              dir_ff;
  logic [5:0]        pre_cnt_ff;
  logic [3:0]        post_cnt_ff;
  logic [14:0]       per_buf_ff;
  logic [14:0]       per_act_ff;
  logic [2:0]        indep_ff;
  logic              lock_ff;
  logic [9:0]        dtc_ff;
  logic              event_ff;
  logic [31:0]       prdata_ff;
  logic              mapped_ff;
  logic              acc;
  logic              setup;
  logic              wr_ctrl;
  logic              wr_count;
  logic              wr_per;
  logic              wr_outcfg;
  logic              wr_outctl;
  logic              wr_dtc;
  logic [N_DUTY-1:0] wr_duty;
  logic [5:0]        pre_term;
  logic              tick;
  logic              at_per;
  logic              at_zero;
  logic              center;
  logic              wrap;
  logic              turn_dn;
  logic              turn_up;
  logic              raw_ev;
  logic              post_mode;
  logic              dis_load;
  logic              per_load;
  logic              duty_load;
  logic              half;
  logic [15:0]       cnt_ext;
  logic [15:0]       duty_buf [N_DUTY];
  logic [N_DUTY-1:0] cmp;
  logic [N_PAIR-1:0] hi;
  logic [N_PAIR-1:0] lo;
  logic [31:0]       nxt_prdata;
  logic              nxt_mapped;
  pwmtb_dt_if        dt_bus ();

  // Address decode, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= ADDR_STATUS) && (a[1:0] == 2'h0);
  endfunction

  // APB strobes: writes take effect only at the access edge
  assign setup     = PSEL && !PENABLE;
  assign acc       = PSEL && PENABLE && PWRITE && mapped_ff;
  assign wr_ctrl   = acc && PADDR == ADDR_CTRL;
  assign wr_count  = acc && PADDR == ADDR_COUNT;
  assign wr_per    = acc && PADDR == ADDR_PERIOD;
  assign wr_outcfg = acc && PADDR == ADDR_OUTCFG;
  assign wr_outctl = acc && PADDR == ADDR_OUTCTL;
  assign wr_dtc    = acc && PADDR == ADDR_DTCTL;
  generate
    for (genvar d = 0; d < N_DUTY; d++)
    begin : g_wdec
      assign wr_duty[d] = acc && PADDR == ADDR_DUTY0 + 8'(4 * d);
    end
  endgenerate

  // Zero wait states; read data was captured in the setup cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped_ff;
  assign PRDATA  = prdata_ff;

  // Read mux
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_mapped = is_mapped(PADDR);
    case (PADDR)
      ADDR_CTRL:   nxt_prdata[15:0] = {run_ff, 7'h00, post_sel_ff, pre_sel_ff, mode_ff};
      ADDR_COUNT:  nxt_prdata[15:0] = {dir_ff, count_ff};
      ADDR_PERIOD: nxt_prdata[14:0] = per_buf_ff;
      ADDR_OUTCFG: nxt_prdata[2:0]  = indep_ff;
      ADDR_OUTCTL: nxt_prdata[0]    = lock_ff;
      ADDR_DTCTL:  nxt_prdata[9:0]  = dtc_ff;
      ADDR_STATUS: nxt_prdata[14:0] = per_act_ff;
      default:
      begin
        if (PADDR >= ADDR_DUTY0 && PADDR < ADDR_OUTCFG)
          nxt_prdata[15:0] = duty_buf[PADDR[3:2] - 2'h3];
      end
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      prdata_ff <= 32'h0000_0000;
      mapped_ff <= 1'b0;
    end
    else if (setup)
    begin
      prdata_ff <= nxt_prdata;
      mapped_ff <= nxt_mapped;
    end
  end

  // Control register; a software write wins over the one-shot stop
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      run_ff      <= CTRL_RST[CTRL_RUN_BIT];
      post_sel_ff <= CTRL_RST[CTRL_POS_LSB +: 4];
      pre_sel_ff  <= CTRL_RST[CTRL_PRE_LSB +: 2];
      mode_ff     <= CTRL_RST[1:0];
    end
    else if (wr_ctrl)
    begin
      run_ff      <= PWDATA[CTRL_RUN_BIT];
      post_sel_ff <= PWDATA[CTRL_POS_LSB +: 4];
      pre_sel_ff  <= PWDATA[CTRL_PRE_LSB +: 2];
      mode_ff     <= PWDATA[1:0];
    end
    else if (wrap && mode_ff == MODE_ONESHOT)
      run_ff <= 1'b0;
  end

  // Other software registers
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      per_buf_ff <= PER_RST;
      indep_ff   <= INDEP_RST;
      lock_ff    <= 1'b0;
      dtc_ff     <= DTC_RST;
    end
    else
    begin
      if (wr_per) per_buf_ff <= PWDATA[14:0];
      if (wr_outcfg) indep_ff <= PWDATA[2:0];
      if (wr_outctl) lock_ff <= PWDATA[0];
      if (wr_dtc) dtc_ff <= PWDATA[9:0];
    end
  end

  // Prescaler; a zero active period freezes the time base
  assign pre_term = pwmtb_pre_term(pre_sel_ff);
  assign tick     = run_ff && pre_cnt_ff == pre_term && per_act_ff != PER_RST;
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || wr_count || wr_ctrl) pre_cnt_ff <= 6'h00;
    else if (run_ff) pre_cnt_ff <= (pre_cnt_ff == pre_term) ? 6'h00 : pre_cnt_ff + 6'h01;
  end

  // Second half of a prescaled count gives the duty LSB its meaning
  assign half    = pre_term != 6'h00 && pre_cnt_ff > (pre_term >> 1);
  assign cnt_ext = {count_ff, half};

  // Time base events
  assign center  = mode_ff[1];
  assign at_per  = count_ff == per_act_ff;
  assign at_zero = count_ff == 15'h0000;
  assign wrap    = tick && !center && at_per;
  assign turn_dn = tick && center && !dir_ff && at_per;
  assign turn_up = tick && center && dir_ff && at_zero;

  // Counter and direction
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      count_ff <= 15'h0000;
      dir_ff   <= 1'b0;
    end
    else if (wr_count)
      count_ff <= PWDATA[14:0];
    else if (!center)
    begin
      dir_ff <= 1'b0;
      if (tick) count_ff <= wrap ? 15'h0000 : count_ff + 15'h0001;
    end
    else if (tick)
    begin
      if (turn_dn)
      begin
        dir_ff   <= 1'b1;
        count_ff <= count_ff - 15'h0001;
      end
      else if (turn_up)
      begin
        dir_ff   <= 1'b0;
        count_ff <= count_ff + 15'h0001;
      end
      else if (dir_ff) count_ff <= count_ff - 15'h0001;
      else count_ff <= count_ff + 15'h0001;
    end
  end

  // Event source per mode; only free-running and up/down are postscaled
  always_comb
  begin
    raw_ev    = 1'b0;
    post_mode = 1'b0;
    case (mode_ff)
      MODE_FREE:
      begin
        raw_ev    = wrap;
        post_mode = 1'b1;
      end
      MODE_ONESHOT: raw_ev = wrap;
      MODE_UPDN:
      begin
        raw_ev    = turn_up;
        post_mode = 1'b1;
      end
      MODE_DBL: raw_ev = turn_up || turn_dn;
      default:  raw_ev = 1'b0;
    endcase
  end

  // Postscaler counts events and lets every (select+1)th one through
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || wr_count || wr_ctrl) post_cnt_ff <= 4'h0;
    else if (raw_ev && post_mode)
      post_cnt_ff <= (post_cnt_ff == post_sel_ff) ? 4'h0 : post_cnt_ff + 4'h1;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST) event_ff <= 1'b0;
    else event_ff <= raw_ev && (!post_mode || post_cnt_ff == post_sel_ff);
  end
  assign TB_EVENT = event_ff;

  // Buffer loads; lockout holds all boundary loads
  assign dis_load  = !run_ff && (!lock_ff || center);
  assign per_load  = (!lock_ff && (wrap || turn_up)) || dis_load;
  assign duty_load = (!lock_ff && (wrap || turn_up ||
                     (mode_ff == MODE_DBL && turn_dn))) || dis_load;

  // Active period; a period of one in double-update mode is left to software
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST) per_act_ff <= PER_RST;
    else if (per_load) per_act_ff <= per_buf_ff;
  end

  // Duty units, one per duty register
  generate
    for (genvar d = 0; d < N_DUTY; d++)
    begin : g_duty
      pwmtb_duty u_duty (
        .clk     (SYS_CLK),
        .srst    (SRST),
        .wr      (wr_duty[d]),
        .wdata   (PWDATA[15:0]),
        .load    (duty_load),
        .cnt_ext (cnt_ext),
        .period  (per_act_ff),
        .center  (center),
        .buf_val (duty_buf[d]),
        .cmp     (cmp[d])
      );
    end
  endgenerate

  // Dead-time settings fan out to every pair
  assign dt_bus.dt_val = dtc_ff[DT_W-1:0];
  assign dt_bus.ps_a   = dtc_ff[DTC_PSA_LSB +: 2];
  assign dt_bus.ps_b   = dtc_ff[DTC_PSB_LSB +: 2];
  assign dt_bus.dt_wr  = wr_dtc;

  // Units one to three feed pairs one to three
  generate
    for (genvar p = 0; p < N_PAIR; p++)
    begin : g_pair
      pwmtb_deadtime u_dt (
        .clk    (SYS_CLK),
        .srst   (SRST),
        .cmp    (cmp[p]),
        .indep  (indep_ff[p]),
        .dtc    (dt_bus.unit),
        .hi_out (hi[p]),
        .lo_out (lo[p])
      );
    end
  endgenerate

  assign PAIR_ONE_HIGH_OUT   = hi[0];
  assign PAIR_ONE_LOW_OUT    = lo[0];
  assign PAIR_TWO_HIGH_OUT   = hi[1];
  assign PAIR_TWO_LOW_OUT    = lo[1];
  assign PAIR_THREE_HIGH_OUT = hi[2];
  assign PAIR_THREE_LOW_OUT  = lo[2];

  // Checks on the time base
  AST_EDGE_WRAP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wrap && !wr_count |=> count_ff == 15'h0000)
    else $error("edge mode did not wrap to zero");
  AST_TURN_DOWN: assert property (@(posedge SYS_CLK) disable iff (SRST)
    turn_dn && !wr_count |=> dir_ff && count_ff == $past(count_ff) - 15'h0001)
    else $error("up/down count did not reverse after period match");
  AST_TURN_UP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    turn_up && !wr_count |=> !dir_ff && count_ff == 15'h0001)
    else $error("direction flag wrong after zero turn");
  AST_ONESHOT_STOP: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wrap && mode_ff == MODE_ONESHOT && !wr_ctrl |=> !run_ff)
    else $error("single-shot did not clear run bit");
  AST_DBL_EVENT: assert property (@(posedge SYS_CLK) disable iff (SRST)
    mode_ff == MODE_DBL && (turn_up || turn_dn) |=> TB_EVENT)
    else $error("double-update event missing");
  AST_UPDN_NO_DN_EV: assert property (@(posedge SYS_CLK) disable iff (SRST)
    mode_ff == MODE_UPDN && !turn_up |=> !TB_EVENT)
    else $error("up/down event outside zero turn");
  AST_PRE_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wr_ctrl && !tick |=> pre_cnt_ff == 6'h00 && count_ff == $past(count_ff))
    else $error("control write did not clear prescaler or moved count");
  AST_POST_DIV: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wr_count |=> post_cnt_ff == 4'h0)
    else $error("count write did not clear postscaler");
  // A control or count write restarts the prescaler, so only windows free of those writes are judged
  AST_TICK_RATE: assert property (@(posedge SYS_CLK) disable iff (SRST)
    tick && pre_sel_ff == 2'h1 && !wr_ctrl && !wr_count ##1
    !wr_ctrl && !wr_count ##1 !wr_ctrl && !wr_count |-> !tick && !$past(tick) ##1 !tick)
    else $error("prescale by four ticked early");
  AST_PER_DIS: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !run_ff && center |=> per_act_ff == $past(per_buf_ff))
    else $error("period buffer not loaded while disabled");
  AST_DBL_LOAD: assert property (@(posedge SYS_CLK) disable iff (SRST)
    mode_ff == MODE_DBL && turn_dn && !lock_ff |-> duty_load)
    else $error("double-update duty load missing at period match");
  CVR_TURN_DN: cover property (@(posedge SYS_CLK) disable iff (SRST) turn_dn);
  CVR_WRAP: cover property (@(posedge SYS_CLK) disable iff (SRST) wrap ##1 TB_EVENT);
  CVR_PAIR: cover property (@(posedge SYS_CLK) disable iff (SRST)
    PAIR_ONE_HIGH_OUT ##[1:100] PAIR_ONE_LOW_OUT);
endmodule

// ==== verification/pwmtb_gate.sv ====
// Gate driver model for one complementary output pair.
// Assumes active-high gate inputs, sampled on the block clock.
`timescale 1ns/10ps
module pwmtb_gate
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hi,
  input  wire logic lo,
  output int        ovl
);
  // Counts cycles where both switches conduct, which would short the bridge leg
  always @(posedge clk)
    if (rst)
      ovl <= 0;
    else
      ovl <= ovl + int'(hi === 1'b1 && lo === 1'b1);
endmodule

// ==== verification/tb_pwmtb_top.sv ====
// Self-checking bench for the PWM time base, duty and dead-time block.
// Assumes the APB map and registered pair outputs of the top level.
`timescale 1ns/10ps
module tb_pwmtb_top;
  import pwmtb_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd;
  logic        prdy, perr, eq, ev;
  logic [5:0]  po;
  logic [1:0]  sd;
  int          ovl, nh, nl, ne;
  int          num_errors = 0;
  int          check_count = 0;
  pwmtb_top dut (.SYS_CLK(clk), .SRST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .TB_EVENT(ev),
    .PAIR_ONE_HIGH_OUT(po[0]), .PAIR_ONE_LOW_OUT(po[1]), .PAIR_TWO_HIGH_OUT(po[2]),
    .PAIR_TWO_LOW_OUT(po[3]), .PAIR_THREE_HIGH_OUT(po[4]), .PAIR_THREE_LOW_OUT(po[5]));
  pwmtb_gate gate (.clk(clk), .rst(rst), .hi(po[0]), .lo(po[1]), .ovl(ovl));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (prdy !== 1'b1 && i < 20);
    if (prdy !== 1'b1)
    begin
      num_errors++;
      finish_test();
    end
    else
    begin
      rd = prd;
      eq = perr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  // Counts active cycles of pair one and events over n cycles
  task meas(input int n);
    nh = 0;
    nl = 0;
    ne = 0;
    repeat (n)
    begin
      @(posedge clk);
      nh += int'(po[0] === 1'b1);
      nl += int'(po[1] === 1'b1);
      ne += int'(ev === 1'b1);
    end
  endtask
  task t_reset;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, eq});
    meas(10);
    chk("idle", 0, nh + ne);
    chk("idle_lo", 10, nl);
    chk("pairs", 32'h2A, {26'h0, po});
    $display("done reset");
  endtask
  task t_edge;
    apb(1'b1, ADDR_PERIOD, 32'h9);
    apb(1'b1, ADDR_DUTY0, 32'hA);
    apb(1'b1, ADDR_CTRL, 32'h8000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("period", 32'h9, rd);
    meas(20);
    meas(40);
    chk("hi", 20, nh);
    chk("lo", 20, nl);
    chk("ev", 4, ne);
    apb(1'b1, ADDR_DUTY0, 32'h20);
    meas(20);
    meas(20);
    chk("full", 20, nh);
    apb(1'b1, ADDR_DUTY0, 32'h0);
    meas(20);
    meas(20);
    chk("none", 0, nh);
    apb(1'b1, ADDR_CTRL, 32'h8010);
    meas(20);
    meas(40);
    chk("post", 2, ne);
    apb(1'b1, ADDR_CTRL, 32'h8004);
    meas(40);
    meas(80);
    chk("pre", 2, ne);
    $display("done edge");
  endtask
  task t_dead;
    apb(1'b1, ADDR_CTRL, 32'h8000);
    apb(1'b1, ADDR_PERIOD, 32'h13);
    apb(1'b1, ADDR_DUTY0, 32'h14);
    apb(1'b1, ADDR_DTCTL, 32'h3);
    meas(60);
    meas(20);
    chk("dhi", 7, nh);
    chk("dlo", 7, nl);
    apb(1'b1, ADDR_DTCTL, 32'h43);
    meas(40);
    meas(20);
    chk("ahi", 4, nh);
    chk("alo", 7, nl);
    chk("short", 0, ovl);
    apb(1'b1, ADDR_OUTCFG, 32'h1);
    meas(40);
    meas(20);
    chk("ihi", 10, nh);
    chk("ilo", 10, nl);
    apb(1'b1, ADDR_OUTCFG, 32'h0);
    apb(1'b1, ADDR_DTCTL, 32'h0);
    $display("done dead");
  endtask
  task t_updn;
    apb(1'b1, ADDR_CTRL, 32'h8002);
    apb(1'b1, ADDR_DUTY0, 32'h26);
    meas(80);
    meas(76);
    chk("ev10", 2, ne);
    chk("cfull", 76, nh);
    sd = 2'b00;
    repeat (20)
    begin
      apb(1'b0, ADDR_COUNT, 32'h0);
      sd[rd[15]] = 1'b1;
    end
    chk("dir", 32'h3, {30'h0, sd});
    apb(1'b1, ADDR_CTRL, 32'h8003); // Period stays 19, never 1
    meas(80);
    meas(76);
    chk("ev11", 4, ne);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_PERIOD, 32'h15);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("dis_per", 32'h15, rd);
    $display("done updn");
  endtask
  task t_shot;
    apb(1'b1, ADDR_CTRL, 32'h8001);
    meas(60);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("run", 32'h0, {31'h0, rd[15]});
    apb(1'b1, ADDR_COUNT, 32'h5);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("count", 32'h5, {17'h0, rd[14:0]});
    $display("done shot");
  endtask
  // Reset for 4 cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_edge();
    t_dead();
    t_updn();
    t_shot();
    finish_test();
  end
endmodule
